// ==== rtl/rx_lane_defines.vh ====
// Constants for the receive lane configuration register block.
// Assumes inclusion by design files only; definitions, no logic.
`ifndef RX_LANE_DEFINES_VH
`define RX_LANE_DEFINES_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define RX_CFG_OFFSET      12'h000
`define RX_CFG_RESET       32'h0000_0000
`define RX_ADDR_BITS       12

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F_EQ_HI            22
`define F_EQ_LO            19
`define F_REC_HI           18
`define F_REC_LO           16
`define F_LOSS_HI          15
`define F_LOSS_LO          14
`define F_ALIGN_HI         13
`define F_ALIGN_LO         12
`define F_RSV11            11
`define F_TERM_HI          10
`define F_TERM_LO          8
`define F_POL              7
`define F_RATE_HI          6
`define F_RATE_LO          5
`define F_WIDTH_HI         4
`define F_WIDTH_LO         2
`define F_RSV1             1
`define F_ENABLE           0
`define F_RSV25_24_HI      25
`define F_RSV25_24_LO      24

// Writable bits: 25..24 and 22..0; 31..26 and 23 read zero
`define RX_CFG_WMASK       32'h037F_FFFF

// ----------------------------------------
// Field codes
// ----------------------------------------
`define ALIGN_OFF          2'h0
`define ALIGN_COMMA        2'h1
`define ALIGN_JOG          2'h2
`define LOSS_OFF           2'h0
`define LOSS_HIGH          2'h1
`define LOSS_LOW           2'h2
`define RATE_FULL          2'h0
`define RATE_HALF          2'h1
`define RATE_QUARTER       2'h2
`define SYMBOL_BITS        10
`define COMMA_PATTERN      7'h1F

`endif

// ==== rtl/rx_field_decode.v ====
// Decodes the recovery field into order and fast lock flags, and the loss and rate fields into one-hot selects.
// Assumes the fields come straight from the configuration register.
`timescale 1ns/1ps
module rx_field_decode (
    input  wire [2:0] recovery_algorithm_select,
    input  wire [1:0] signal_loss_threshold,
    input  wire [1:0] rate_select,
    output wire       rec_second_order,
    output wire       rec_fast_lock,
    output wire [1:0] rec_order_speed,
    output wire       loss_detect_enable,
    output wire       loss_high_threshold,
    output wire       loss_low_threshold,
    output wire       rate_full,
    output wire       rate_half,
    output wire       rate_quarter
);
`include "rx_lane_defines.vh"

    // R5: recovery algorithm decode
    assign rec_fast_lock    = recovery_algorithm_select[2];
    assign rec_order_speed  = recovery_algorithm_select[1:0];
    assign rec_second_order = (recovery_algorithm_select[1:0] != 2'h0);

    // R6: signal loss decode, reserved code detects nothing
    assign loss_high_threshold = (signal_loss_threshold == `LOSS_HIGH);
    assign loss_low_threshold  = (signal_loss_threshold == `LOSS_LOW);
    assign loss_detect_enable  = loss_high_threshold | loss_low_threshold;

    // R14: rate decode, reserved code selects nothing
    assign rate_full    = (rate_select == `RATE_FULL);
    assign rate_half    = (rate_select == `RATE_HALF);
    assign rate_quarter = (rate_select == `RATE_QUARTER);

endmodule

// ==== rtl/rx_symbol_align.v ====
// Symbol aligner: holds a bit offset into a 20-bit window of received bits.
// Assumes one serial bit per enabled clock, already polarity corrected.
`timescale 1ns/1ps
module rx_symbol_align #(
    parameter SYM_BITS = 10
) (
    input  wire                clk,
    input  wire                rst,
    input  wire                ce,
    input  wire                enable,
    input  wire [1:0]          align_mode,
    input  wire                bit_in,
    output reg  [SYM_BITS-1:0] symbol,
    output reg                 symbol_valid,
    output reg  [3:0]          offset,
    output reg                 jog_pulse
);
`include "rx_lane_defines.vh"

    reg  [2*SYM_BITS-1:0] shreg;
    reg  [3:0]            bitcnt;
    reg  [1:0]            prev_mode;
    reg  [3:0]            comma_pos;
    reg                   comma_found;
    integer               i;

    wire jog_edge = ~prev_mode[1] & align_mode[1];

    // Comma search over every symbol start; the comma fills the first seven bits of a symbol
    always @* begin
        comma_found = 1'b0;
        comma_pos   = 4'h0;
        for (i = 0; i < SYM_BITS; i = i + 1) begin
            if (!comma_found && ((shreg[i + 3 +: 7] == `COMMA_PATTERN) || (shreg[i + 3 +: 7] == ~`COMMA_PATTERN))) begin
                comma_found = 1'b1;
                comma_pos   = i[3:0];
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            shreg        <= {2*SYM_BITS{1'b0}};
            bitcnt       <= 4'h0;
            prev_mode    <= 2'h0;
            offset       <= 4'h0;
            symbol       <= {SYM_BITS{1'b0}};
            symbol_valid <= 1'b0;
            jog_pulse    <= 1'b0;
        end else if (ce) begin
            prev_mode    <= align_mode;
            symbol_valid <= 1'b0;
            jog_pulse    <= 1'b0;
            if (enable) begin
                shreg <= {shreg[2*SYM_BITS-2:0], bit_in};
                if (bitcnt == SYM_BITS - 1) begin
                    bitcnt       <= 4'h0;
                    symbol       <= shreg[offset +: SYM_BITS];
                    symbol_valid <= 1'b1;
                end else begin
                    bitcnt <= bitcnt + 4'h1;
                end
            end
            // R9: one bit jog on 0x to 1x change
            if (jog_edge) begin
                jog_pulse <= 1'b1;
                offset    <= (offset == SYM_BITS - 1) ? 4'h0 : offset + 4'h1;
            // R8: realign on misaligned comma
            // Judged only at a symbol boundary; mid-symbol the comma slides one place per bit
            end else if (enable && bitcnt == SYM_BITS - 1 && align_mode == `ALIGN_COMMA && comma_found
                         && comma_pos != offset) begin
                offset <= comma_pos;
            end
            // R7: code 00 never moves the offset, even on entry
        end
    end

endmodule

// ==== rtl/rx_lane_config.v ====
// Receive lane configuration register with APB slave access.
// Assumes an APB master on clk; the analog receiver consumes the field outputs.
`timescale 1ns/1ps
`include "rx_lane_defines.vh"

// Function
// R1: Bits 31 to 26 always read as zero.
// R2: Software writes zeros to bits 25 and 24.
// R3: Bit 23 always reads as zero.
// R4: Four-bit equalizer field held fully writable and driven to receiver.
// R5: Three-bit recovery code decodes order and fast lock.
// R6: Loss field: off, high threshold, low threshold, reserved.
// R7: Alignment code 00 performs no alignment, held or on entry.
// R8: Alignment code 01 realigns on a misaligned comma.
// R9: Upper alignment bit rising jogs alignment by exactly one bit.
// R10: Software writes zero to bit 11.
// R11: Software programs termination only with 001.
// R12: Polarity bit set inverts the receive pair before recovery.
// R13: Polarity clear means true line is positive, set means negative.
// R14: Rate field: full, half, quarter, reserved.
// R15: Software writes 000 to the parallel width field.
// R16: Enable bit zero disables receiver, one enables it.
// R17: Writable fields reset to zero and read back last written value.
module rx_lane_config #(
    parameter SYM_BITS = `SYMBOL_BITS
) (
    input  wire                clk,
    input  wire                rst,
    input  wire                ce,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output wire                pready,
    output reg  [31:0]         prdata,
    output wire                pslverr,
    input  wire                receive_differential_line,
    output wire                recovered_bit,
    output wire [SYM_BITS-1:0] rx_symbol,
    output wire                rx_symbol_valid,
    output wire [3:0]          align_offset,
    output wire                align_jog,
    output wire [3:0]          equalizer_setting,
    output wire [2:0]          recovery_algorithm_select,
    output wire                rec_second_order,
    output wire                rec_fast_lock,
    output wire [1:0]          rec_order_speed,
    output wire [1:0]          signal_loss_threshold,
    output wire                loss_detect_enable,
    output wire                loss_high_threshold,
    output wire                loss_low_threshold,
    output wire [2:0]          termination_select,
    output wire                receive_polarity_swap,
    output wire                rate_full,
    output wire                rate_half,
    output wire                rate_quarter,
    output wire [2:0]          parallel_width_select,
    output wire                receiver_enable
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg  [31:0] receive_lane_configuration;
    reg  [31:0] next_prdata;
    reg         line_q;

    wire hit     = (paddr == `RX_CFG_OFFSET);
    wire access  = psel & penable;
    wire wr_take = access & pwrite & hit & ce;

    // Single cycle access phase; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    always @(posedge clk) begin
        if (rst) begin
            // R17: reset to zero
            receive_lane_configuration <= `RX_CFG_RESET;
        end else if (wr_take) begin
            // R17: capture written value
            // R1: R3: read-only bits never stored
            receive_lane_configuration <= pwdata & `RX_CFG_WMASK;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Read data leaves a flop loaded in the setup cycle so it is steady in the access phase
    always @* begin
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            next_prdata = hit ? (receive_lane_configuration & `RX_CFG_WMASK) : 32'h0000_0000;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (ce) begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    // R4: equalizer field to receiver
    assign equalizer_setting         = receive_lane_configuration[`F_EQ_HI:`F_EQ_LO];
    assign recovery_algorithm_select = receive_lane_configuration[`F_REC_HI:`F_REC_LO];
    assign signal_loss_threshold     = receive_lane_configuration[`F_LOSS_HI:`F_LOSS_LO];
    // R11: passed through as written; software keeps it valid
    assign termination_select        = receive_lane_configuration[`F_TERM_HI:`F_TERM_LO];
    assign receive_polarity_swap     = receive_lane_configuration[`F_POL];
    // R15: passed through; software keeps it zero
    assign parallel_width_select     = receive_lane_configuration[`F_WIDTH_HI:`F_WIDTH_LO];
    // R16: receiver enable bit
    assign receiver_enable           = receive_lane_configuration[`F_ENABLE];

    rx_field_decode u_decode (
        .recovery_algorithm_select (recovery_algorithm_select),
        .signal_loss_threshold     (signal_loss_threshold),
        .rate_select               (receive_lane_configuration[`F_RATE_HI:`F_RATE_LO]),
        .rec_second_order          (rec_second_order),
        .rec_fast_lock             (rec_fast_lock),
        .rec_order_speed           (rec_order_speed),
        .loss_detect_enable        (loss_detect_enable),
        .loss_high_threshold       (loss_high_threshold),
        .loss_low_threshold        (loss_low_threshold),
        .rate_full                 (rate_full),
        .rate_half                 (rate_half),
        .rate_quarter              (rate_quarter)
    );

    // ----------------------------------------
    // Receive data path
    // ----------------------------------------
    // R12: R13: polarity swap ahead of recovery
    always @(posedge clk) begin
        if (rst) begin
            line_q <= 1'b0;
        end else if (ce) begin
            line_q <= receive_differential_line ^ receive_polarity_swap;
        end
    end

    // R16: gated to zero while disabled
    assign recovered_bit = line_q & receiver_enable;

    rx_symbol_align #(
        .SYM_BITS (SYM_BITS)
    ) u_align (
        .clk          (clk),
        .rst          (rst),
        .ce           (ce),
        .enable       (receiver_enable),
        .align_mode   (receive_lane_configuration[`F_ALIGN_HI:`F_ALIGN_LO]),
        .bit_in       (line_q),
        .symbol       (rx_symbol),
        .symbol_valid (rx_symbol_valid),
        .offset       (align_offset),
        .jog_pulse    (align_jog)
    );

endmodule

// ==== sim/rx_lane_config_monitor.sv ====
// Checker for the receive lane configuration register.
// Assumes it is bound to rx_lane_config and sees only its ports.
`timescale 1ns/1ps
module rx_lane_config_monitor (
    input wire logic        clk, rst, ce, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0]  align_offset, equalizer_setting,
    input wire logic [2:0]  recovery_algorithm_select, termination_select, parallel_width_select,
    input wire logic [1:0]  signal_loss_threshold,
    input wire logic        receive_differential_line, recovered_bit, align_jog, rec_second_order,
    input wire logic        rec_fast_lock, loss_detect_enable, loss_high_threshold, loss_low_threshold,
    input wire logic        receive_polarity_swap, rate_full, rate_half, rate_quarter, receiver_enable
);
    // --------------------------------
    // Shadow of the last accepted word
    // --------------------------------
    logic [31:0] sh;
    always @(posedge clk)
        if (rst) sh <= 32'h0000_0000;
        else if (ce && psel && penable && pwrite && paddr == 12'h000) sh <= pwdata & 32'h037F_FFFF;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // --------------------------------
    // Properties
    // --------------------------------
    AST_RSV_ZERO: assert property (psel && penable && !pwrite |-> prdata[31:26] == 6'h00 && !prdata[23])
        else $error("reserved bits read nonzero");
    AST_READBACK: assert property (psel && penable && !pwrite && paddr == 12'h000 && $past(ce) |-> prdata == sh)
        else $error("read data differs from last write");
    AST_FIELDS: assert property ({equalizer_setting, recovery_algorithm_select, signal_loss_threshold} == sh[22:14]
        && {termination_select, receive_polarity_swap, parallel_width_select, receiver_enable} == {sh[10:7], sh[4:2], sh[0]})
        else $error("field outputs differ from register");
    AST_REC: assert property (rec_fast_lock == sh[18] && rec_second_order == (sh[17:16] != 2'h0))
        else $error("recovery decode wrong");
    AST_LOSS: assert property (sh[15:14] != 2'h3 |-> loss_detect_enable == (sh[15:14] != 2'h0)
        && loss_high_threshold == (sh[15:14] == 2'h1) && loss_low_threshold == (sh[15:14] == 2'h2))
        else $error("loss decode wrong");
    AST_RATE: assert property (sh[6:5] != 2'h3 |-> rate_full == (sh[6:5] == 2'h0)
        && rate_half == (sh[6:5] == 2'h1) && rate_quarter == (sh[6:5] == 2'h2))
        else $error("rate decode wrong");
    AST_POLARITY: assert property (receiver_enable && $past(receiver_enable) && $past(ce)
        |-> recovered_bit == $past(receive_differential_line ^ receive_polarity_swap))
        else $error("recovered bit polarity wrong");
    AST_RX_OFF: assert property (!receiver_enable |-> !recovered_bit)
        else $error("data while receiver disabled");
    AST_ALIGN_HOLD: assert property (sh[13:12] == 2'h0 && $past(sh[13:12]) == 2'h0 && $past(sh[13:12], 2) == 2'h0
        |-> $stable(align_offset))
        else $error("offset moved with alignment off");
    AST_JOG: assert property ($rose(sh[13]) && ce |-> ##[0:2] align_jog)
        else $error("missing jog");
    AST_JOG_ONCE: assert property (align_jog |=> !align_jog)
        else $error("jog longer than one cycle");
endmodule

bind rx_lane_config rx_lane_config_monitor i_mon (.*);

// ==== sim/link_partner.sv ====
// Link partner: serial transmitter on the receive line.
// Assumes one bit per clock, or per two clocks when slow is high.
`timescale 1ns/1ps
module link_partner (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      line
);
    // Comma then its complement, so each ten bits hold one comma
    logic [19:0] pat;
    logic        half;
    always @(posedge clk) begin
        if (rst) begin
            pat  <= 20'h3EB05;
            half <= 1'b0;
        end else begin
            half <= slow & ~half;
            if (!(slow && !half)) pat <= {pat[18:0], pat[19]};
        end
    end
    assign line = pat[19];
endmodule

// ==== sim/rx_lane_config_tb.sv ====
// Testbench for the receive lane configuration register.
// Assumes the checker is bound in and the link partner feeds the line.
`timescale 1ns/1ps
module rx_lane_config_tb;
    logic        clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q, d;
    logic        pready, pslverr, receive_differential_line, recovered_bit, rx_symbol_valid, align_jog, e;
    logic [9:0]  rx_symbol;
    logic [3:0]  align_offset, equalizer_setting, o1;
    logic [2:0]  recovery_algorithm_select, termination_select, parallel_width_select;
    logic [1:0]  signal_loss_threshold, rec_order_speed;
    logic        rec_second_order, rec_fast_lock, loss_detect_enable, loss_high_threshold, loss_low_threshold;
    logic        receive_polarity_swap, rate_full, rate_half, rate_quarter, receiver_enable;
    int          err_total = 0, n_checks = 0, jogs = 0, syms = 0;

    rx_lane_config i_dut (.*);
    link_partner i_far (.clk(clk), .rst(rst), .slow(slow), .line(receive_differential_line));

    always #12.5 clk = ~clk;
    always @(posedge clk) if (align_jog === 1'b1) jogs++;
    always @(posedge clk) if (rx_symbol_valid === 1'b1) syms++;

    // --------------------------------
    // Helpers
    // --------------------------------
    // Software keeps 25:24, 11, 4:2 and 1 at zero and termination at 001
    // legal software writes
    function automatic logic [31:0] legal(input logic [31:0] r);
        return (r & 32'hFCFF_F0E1) | 32'h0000_0100;
    endfunction
    function automatic logic [31:0] exp_rd(input logic [31:0] w);
        return w & 32'h037F_FFFF;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            final_report;
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask

    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        void'($urandom(32'h2EDA361D));
        repeat (6) @(posedge clk);
        rst <= 0;
        apb(0, 12'h000, 0);
        chk(q, 32'h0);
        chk({receiver_enable, rate_full}, 2'b01);
        $display("test reset done");
        repeat (30) begin
            d = legal($urandom);
            slow <= d[5];
            apb(1, 12'h000, d);
            apb(0, 12'h000, 0);
            chk(q, exp_rd(d));
            chk({equalizer_setting, receive_polarity_swap, receiver_enable}, {d[22:19], d[7], d[0]});
        end
        $display("test random words done");
        for (int k = 0; k < 8; k++) begin
            apb(1, 12'h000, {13'h0, k[2:0], k[1:0], 7'h02, k[1:0], 5'h00});
            settle(0);
            chk({rec_fast_lock, rec_second_order, rec_order_speed}, {k[2], k[1:0] != 0, k[1:0]});
            if (k < 3) chk({loss_detect_enable, loss_high_threshold, loss_low_threshold, rate_full, rate_half,
                rate_quarter}, {k != 0, k == 1, k == 2, k == 0, k == 1, k == 2});
        end
        $display("test decodes done");
        d = legal($urandom);
        apb(1, 12'h000, d);
        chk(e, 1'b0);
        apb(1, 12'h004, ~d);
        chk(e, 1'b1);
        apb(0, 12'h004, 0);
        chk(q, 32'h0);
        ce <= 0;
        apb(1, 12'h000, 32'h0000_0100);
        ce <= 1;
        apb(0, 12'h000, 0);
        chk(q, exp_rd(d));
        $display("test refused writes done");
        slow <= 0;
        apb(1, 12'h000, 32'h0000_1101);
        settle(60);
        o1 = align_offset;
        syms = 0;
        settle(40);
        chk(align_offset, o1);
        chk(syms, 4);
        chk(rx_symbol == 10'h0FA || rx_symbol == 10'h305, 1'b1);
        jogs = 0;
        apb(1, 12'h000, 32'h0000_2101);
        settle(5);
        chk(jogs, 1);
        chk(align_offset, (o1 + 1) % 10);
        apb(1, 12'h000, 32'h0000_0101);
        settle(60);
        chk(align_offset, (o1 + 1) % 10);
        chk(jogs, 1);
        apb(1, 12'h000, 32'h0000_1101);
        settle(60);
        chk(align_offset, o1);
        $display("test alignment done");
        final_report;
    end
endmodule
